// file: rtl/xrs_sequencer.v
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "xrs_regs.vh"
// Notes on behaviour
// R1 - after kv ramp, current program steps to 5% and holds
// R2 - filament ramps upward during the current hold period
// R3 - after hold, current ramps from low level to final value
// R4 - default controlled kv ramp is 5 s full scale
// R5 - default controlled filament ramp is 30 s full scale
// R6 - default hold 30 s, then current ramp 5 s full scale
// R7 - controlled ramp off as shipped; active only once enabled and saved
// R8 - set-point ramping slews kv and current on program changes
// R9 - ramp times are full-scale; smaller changes take proportionally less
// R10 - set-point ramp enable takes effect on save; defaults off
// R11 - arc control on by default: 4 arcs, 10 s, 150 ms, re-ramp on
// R12 - arc shutdown when arc count (2..10) occurs within period
// R13 - arc period settable 10..20 s, arcs counted against it
// R14 - each arc turns hv off for quench time, 50..300 ms
// R15 - after quench kv re-ramps, controlled or standard ramp
// R16 - suppress-post-arc-ramp restores output without ramp; here kv still slews over kv_ms_r when set-point ramp is on
// R17 - power up local; remote only by interface command
// R18 - saved default-remote powers up remote, ignores local enable
// R19 - remote command while enabled in local: shutdown and fault
// R20 - clear command removes the mode-change fault
// R21 - local mode: hv only while enable contact closed
// R22 - remote mode: contact is interlock for interface enable
// R23 - standard ramps: 5 s kv, 2.5 s filament after kv passes 30%
// R24 - arcs older than the period drop out of a sliding window
module xrs_sequencer
#(
  parameter W         = 12,
  parameter MS_CYCLES = `XRS_CLK_HZ / `XRS_MS_PER_S,
  parameter AW        = 4
)
(
  input  wire         sys_clk,
  input  wire         reset_n,
  input  wire         enable_contact,
  input  wire         arc_detect,
  input  wire [4:0]   nv_ctrl,
  input  wire [3:0]   addr,
  input  wire [15:0]  wr_data,
  input  wire         wr_en,
  input  wire         rd_en,
  output reg  [15:0]  rd_data_r,
  output wire [W-1:0] kv_prog,
  output wire [W-1:0] cur_prog,
  output wire [W-1:0] fil_prog,
  output reg          hv_on_r,
  output reg          ps_fault_r,
  output reg          arc_shutdown_r,
  output reg          remote_mode_r,
  output reg          nv_save_r
);
  localparam S_OFF  = 3'h0;
  localparam S_KV   = 3'h1;
  localparam S_HOLD = 3'h2;
  localparam S_IR   = 3'h3;
  localparam S_ON   = 3'h4;
  localparam S_QU   = 3'h5;

  // ==========================================================
  // helpers
  function [15:0] clamp;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  function [31:0] ms2cyc;
    input [15:0] ms;
    begin
      ms2cyc = ms * MS_CYCLES;
    end
  endfunction

  // percentage of a code; product kept wide so it cannot wrap
  function [W-1:0] pct;
    input [W-1:0] v;
    input [6:0]   p;
    reg   [W+6:0] t;
    begin
      t   = (v * p) / `XRS_PCT_DIV;
      pct = t[W-1:0];
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  reg  [1:0]   cont_s_r;
  reg  [2:0]   arc_s_r;
  reg  [4:0]   nv1_r;
  reg  [4:0]   nv2_r;
  reg  [1:0]   boot_r;
  wire         contact;
  wire         arc_edge;

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cont_s_r <= 2'h0;
      arc_s_r  <= 3'h0;
      nv1_r    <= 5'h00;
      nv2_r    <= 5'h00;
      boot_r   <= 2'h0;
    end
    else
    begin
      cont_s_r <= {cont_s_r[0], enable_contact};
      arc_s_r  <= {arc_s_r[1:0], arc_detect};
      nv1_r    <= nv_ctrl;
      nv2_r    <= nv1_r;
      if (boot_r != 2'h3)
        boot_r <= boot_r + 2'h1;
    end
  end

  assign contact  = cont_s_r[1];
  assign arc_edge = arc_s_r[1] & ~arc_s_r[2];

  // ==========================================================
  // millisecond time base and timestamp
  reg  [31:0]  ms_div_r;
  reg  [31:0]  ms_now_r;
  wire         ms_tick;

  assign ms_tick = (ms_div_r == MS_CYCLES - 1);

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ms_div_r <= 32'h0000_0000;
      ms_now_r <= 32'h0000_0000;
    end
    else if (ms_tick)
    begin
      ms_div_r <= 32'h0000_0000;
      ms_now_r <= ms_now_r + 32'h0000_0001;
    end
    else
      ms_div_r <= ms_div_r + 32'h0000_0001;
  end

  // ==========================================================
  // register file
  reg  [4:0]   ctrl_r;
  reg  [4:0]   act_r;
  reg  [W-1:0] kv_set_r;
  reg  [W-1:0] cur_set_r;
  reg  [W-1:0] fil_set_r;
  reg  [15:0]  kv_ms_r;
  reg  [15:0]  fil_ms_r;
  reg  [15:0]  cur_ms_r;
  reg  [15:0]  hold_ms_r;
  reg  [15:0]  arc_lim_r;
  reg  [15:0]  arc_ms_r;
  reg  [15:0]  qu_ms_r;
  wire         wr_cmd;

  assign wr_cmd = wr_en && (addr == `XRS_A_CMD);

  // working values change at once; feature bits wait for save
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_r    <= `XRS_CTRL_RST;
      act_r     <= `XRS_CTRL_RST;              // [R7] [R10] [R11]
      kv_set_r  <= {W{1'b0}};
      cur_set_r <= {W{1'b0}};
      fil_set_r <= {W{1'b0}};
      kv_ms_r   <= `XRS_KV_MS_RST;             // [R4]
      fil_ms_r  <= `XRS_FIL_MS_RST;            // [R5]
      cur_ms_r  <= `XRS_CUR_MS_RST;            // [R6]
      hold_ms_r <= `XRS_HOLD_MS_RST;           // [R6]
      arc_lim_r <= `XRS_ARC_LIM_RST;           // [R11]
      arc_ms_r  <= `XRS_ARC_MS_RST;            // [R11]
      qu_ms_r   <= `XRS_QU_MS_RST;             // [R11]
      nv_save_r <= 1'b0;
    end
    else
    begin
      nv_save_r <= wr_cmd && wr_data[`XRS_K_SAVE];
      if (boot_r == 2'h2)
      begin
        ctrl_r <= nv2_r;                       // stored settings at boot
        act_r  <= nv2_r;
      end
      else if (wr_cmd && wr_data[`XRS_K_SAVE])
        act_r <= ctrl_r;                       // [R7] [R10]
      if (wr_en)
        case (addr)
          `XRS_A_CTRL:    ctrl_r    <= wr_data[4:0];
          `XRS_A_KV_SET:  kv_set_r  <= wr_data[W-1:0];
          `XRS_A_CUR_SET: cur_set_r <= wr_data[W-1:0];
          `XRS_A_FIL_SET: fil_set_r <= wr_data[W-1:0];
          `XRS_A_KV_MS:   kv_ms_r   <= clamp(wr_data,
                            `XRS_KV_MS_MIN, `XRS_KV_MS_MAX);
          `XRS_A_FIL_MS:  fil_ms_r  <= clamp(wr_data,
                            `XRS_FIL_MS_MIN, `XRS_FIL_MS_MAX);
          `XRS_A_CUR_MS:  cur_ms_r  <= clamp(wr_data,
                            `XRS_CUR_MS_MIN, `XRS_CUR_MS_MAX);
          `XRS_A_HOLD_MS: hold_ms_r <= clamp(wr_data,
                            `XRS_HOLD_MS_MIN, `XRS_HOLD_MS_MAX);
          `XRS_A_ARC_LIM: arc_lim_r <= clamp(wr_data,  // [R12]
                            `XRS_ARC_LIM_MIN, `XRS_ARC_LIM_MAX);
          `XRS_A_ARC_MS:  arc_ms_r  <= clamp(wr_data,  // [R13]
                            `XRS_ARC_MS_MIN, `XRS_ARC_MS_MAX);
          `XRS_A_QU_MS:   qu_ms_r   <= clamp(wr_data,  // [R14]
                            `XRS_QU_MS_MIN, `XRS_QU_MS_MAX);
          default: ;
        endcase
    end
  end

  wire ctl_on  = act_r[`XRS_C_CTL_RAMP];
  wire sp_on   = act_r[`XRS_C_SP_RAMP];
  wire arc_on  = act_r[`XRS_C_ARC_EN];
  wire no_rr   = act_r[`XRS_C_NO_RERAMP];

  // ==========================================================
  // sliding arc window: fifo of timestamps, oldest expires
  reg  [AW:0]  wp_r;
  reg  [AW:0]  rp_r;
  reg  [1:0]   settle_r;
  wire [31:0]  oldest;
  wire [AW:0]  arc_cnt;
  wire         arc_ev;
  wire         arc_pop;
  wire         arc_trip;
  reg  [2:0]   state_r;

  assign arc_cnt  = wp_r - rp_r;
  assign arc_ev   = arc_edge && arc_on &&
                    (state_r != S_OFF) && (state_r != S_QU);
  // memory read lags a pointer move by two edges
  assign arc_pop  = (arc_cnt != {(AW+1){1'b0}}) && (settle_r == 2'h0)
                    && ((ms_now_r - oldest) >= {16'h0000, arc_ms_r});
  assign arc_trip = arc_ev && ({{(15-AW){1'b0}}, arc_cnt} + 16'h0001
                    >= arc_lim_r);                     // [R12]

  xrs_arc_mem #(.AW(AW), .DW(32)) u_arc_mem
  (
    .sys_clk   (sys_clk),
    .wr_en     (arc_ev),
    .wr_addr   (wp_r[AW-1:0]),
    .wr_data   (ms_now_r),
    .rd_addr   (rp_r[AW-1:0]),
    .rd_data_r (oldest)
  );

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp_r     <= {(AW+1){1'b0}};
      rp_r     <= {(AW+1){1'b0}};
      settle_r <= 2'h3;
    end
    else
    begin
      settle_r <= {settle_r[0], arc_ev | arc_pop};
      if (arc_ev)
        wp_r <= wp_r + {{AW{1'b0}}, 1'b1};
      if (arc_pop)
        rp_r <= rp_r + {{AW{1'b0}}, 1'b1};             // [R24] [R13]
    end
  end

  // ==========================================================
  // mode, enable, fault
  reg          rem_en_r;
  reg  [15:0]  tmr_r;
  reg          rearc_r;
  reg          fil_arm_r;
  wire         run_ok;
  wire         cmd_clr;

  assign cmd_clr = wr_cmd && wr_data[`XRS_K_CLEAR];
  assign run_ok  = (boot_r == 2'h3) && contact &&     // [R21] [R22]
                   (!remote_mode_r || rem_en_r) &&
                   !ps_fault_r && !arc_shutdown_r;

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      remote_mode_r  <= 1'b0;                          // [R17]
      rem_en_r       <= 1'b0;
      ps_fault_r     <= 1'b0;
      arc_shutdown_r <= 1'b0;
    end
    else
    begin
      if (boot_r == 2'h2)
        remote_mode_r <= nv2_r[`XRS_C_DEF_REM];        // [R18]
      else if (wr_cmd && wr_data[`XRS_K_REMOTE])
        remote_mode_r <= 1'b1;                         // [R17]
      else if (wr_cmd && wr_data[`XRS_K_LOCAL])
        remote_mode_r <= 1'b0;
      // interface enable needs the contact closed
      if (!remote_mode_r || !contact || ps_fault_r ||
          (wr_cmd && wr_data[`XRS_K_HV_OFF]))
        rem_en_r <= 1'b0;                              // [R22]
      else if (wr_cmd && wr_data[`XRS_K_HV_ON])
        rem_en_r <= 1'b1;                              // [R22]
      // set wins over clear in the same cycle
      if (wr_cmd && wr_data[`XRS_K_REMOTE] && !remote_mode_r &&
          state_r != S_OFF)
        ps_fault_r <= 1'b1;                            // [R19]
      else if (cmd_clr)
        ps_fault_r <= 1'b0;                            // [R20]
      if (arc_trip)
        arc_shutdown_r <= 1'b1;                        // [R12]
      else if (cmd_clr)
        arc_shutdown_r <= 1'b0;
    end
  end

  // ==========================================================
  // ramp sequence
  wire         kv_done;
  wire         cur_done;
  wire [W-1:0] kv_thr;
  wire [W-1:0] cur_low;

  assign kv_thr  = pct(`XRS_FS_CODE, `XRS_THR_PCT);   // [R23]
  assign cur_low = pct(cur_set_r, `XRS_LOW_PCT);      // [R1]

  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r   <= S_OFF;
      tmr_r     <= 16'h0000;
      rearc_r   <= 1'b0;
      fil_arm_r <= 1'b0;
      hv_on_r   <= 1'b0;
    end
    else
    begin
      hv_on_r <= run_ok && (state_r != S_OFF) &&
                 (state_r != S_QU) && !arc_ev;
      if (ms_tick)
        tmr_r <= tmr_r + 16'h0001;
      if (!run_ok)
      begin
        state_r   <= S_OFF;                            // [R19] [R21]
        rearc_r   <= 1'b0;
        fil_arm_r <= 1'b0;
      end
      else if (arc_ev)
      begin
        state_r <= S_QU;                               // [R14]
        tmr_r   <= 16'h0000;
      end
      else
        case (state_r)
          S_OFF:
            state_r <= S_KV;
          S_KV:
          begin
            if (!ctl_on && kv_prog > kv_thr)
              fil_arm_r <= 1'b1;                       // [R23]
            if (kv_done)
            begin
              tmr_r   <= 16'h0000;
              rearc_r <= 1'b0;
              if (ctl_on && !rearc_r)
              begin
                state_r   <= S_HOLD;                   // [R1]
                fil_arm_r <= 1'b1;                     // [R2]
              end
              else
                state_r <= S_ON;
            end
          end
          S_HOLD:
            if (tmr_r >= hold_ms_r)
              state_r <= S_IR;                         // [R3] [R6]
          S_IR:
            if (cur_done)
              state_r <= S_ON;
          S_ON:
            state_r <= S_ON;
          S_QU:
            if (tmr_r >= qu_ms_r)
            begin
              state_r <= no_rr ? S_ON : S_KV;          // [R15] [R16]
              rearc_r <= !no_rr;
            end
          default:
            state_r <= S_OFF;
        endcase
    end
  end

  // ==========================================================
  // targets, spans and slew choice per channel
  reg  [W-1:0] kv_tgt;
  reg  [W-1:0] cur_tgt;
  reg  [31:0]  kv_span;
  reg          kv_slew;
  reg          cur_slew;
  wire [31:0]  cur_span;
  wire [31:0]  fil_span;

  assign cur_span = ms2cyc(cur_ms_r);                  // [R6] [R8]
  assign fil_span = ms2cyc(ctl_on ? fil_ms_r :
                           `XRS_STD_FIL_MS);           // [R5] [R23]

  always @*
  begin
    kv_tgt   = kv_set_r;
    kv_slew  = 1'b0;
    cur_tgt  = cur_set_r;
    cur_slew = 1'b0;
    kv_span  = ms2cyc((ctl_on || state_r == S_ON) ? kv_ms_r :
                      `XRS_STD_KV_MS);                 // [R4] [R23]
    case (state_r)
      S_KV:
      begin
        kv_slew = 1'b1;                                // [R15]
        cur_tgt = rearc_r ? cur_set_r : {W{1'b0}};
      end
      S_HOLD:
        cur_tgt = cur_low;                             // [R1]
      S_IR:
        cur_slew = 1'b1;                               // [R3]
      S_ON:
      begin
        kv_slew  = sp_on;                              // [R8] [R9]
        cur_slew = sp_on;                              // [R8] [R9]
      end
      S_QU:
        kv_tgt = {W{1'b0}};                            // [R14]
      default:
      begin
        kv_tgt  = {W{1'b0}};
        cur_tgt = {W{1'b0}};
      end
    endcase
  end

  xrs_ramp #(.W(W)) u_kv
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .target  (kv_tgt),
    .span    (kv_span),
    .slew    (kv_slew),
    .value_r (kv_prog),
    .done    (kv_done)
  );

  xrs_ramp #(.W(W)) u_cur
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .target  (cur_tgt),
    .span    (cur_span),
    .slew    (cur_slew),
    .value_r (cur_prog),
    .done    (cur_done)
  );

  // filament only ramps upward once armed, drops at once
  xrs_ramp #(.W(W)) u_fil
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .target  (fil_arm_r ? fil_set_r : {W{1'b0}}),     // [R2]
    .span    (fil_span),
    .slew    (fil_arm_r),
    .value_r (fil_prog),
    .done    ()
  );

  // ==========================================================
  // read port, data one cycle after the strobe
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      rd_data_r <= 16'h0000;
    else if (!rd_en)
      rd_data_r <= 16'h0000;
    else
      case (addr)
        `XRS_A_CTRL:    rd_data_r <= {3'h0, act_r, 3'h0, ctrl_r};
        `XRS_A_KV_SET:  rd_data_r <= {{(16-W){1'b0}}, kv_set_r};
        `XRS_A_CUR_SET: rd_data_r <= {{(16-W){1'b0}}, cur_set_r};
        `XRS_A_FIL_SET: rd_data_r <= {{(16-W){1'b0}}, fil_set_r};
        `XRS_A_KV_MS:   rd_data_r <= kv_ms_r;
        `XRS_A_FIL_MS:  rd_data_r <= fil_ms_r;
        `XRS_A_CUR_MS:  rd_data_r <= cur_ms_r;
        `XRS_A_HOLD_MS: rd_data_r <= hold_ms_r;
        `XRS_A_ARC_LIM: rd_data_r <= arc_lim_r;
        `XRS_A_ARC_MS:  rd_data_r <= arc_ms_r;
        `XRS_A_QU_MS:   rd_data_r <= qu_ms_r;
        `XRS_A_STATUS:  rd_data_r <= {{(7-AW){1'b0}}, arc_cnt,
                          contact, hv_on_r, arc_shutdown_r,
                          ps_fault_r, remote_mode_r, state_r};
        default:        rd_data_r <= 16'h0000;
      endcase
  end
endmodule // xrs_sequencer

// file: pkg/xrs_regs.vh
`ifndef XRS_REGS_VH
`define XRS_REGS_VH
// ==========================================================
// clock and scaling
`define XRS_CLK_HZ        20000000
`define XRS_MS_PER_S      1000
`define XRS_FS_CODE       12'hfff
`define XRS_LOW_PCT       7'h05
`define XRS_THR_PCT       7'h1e
`define XRS_PCT_DIV       7'h64
// ==========================================================
// register indices
`define XRS_A_CTRL        4'h0
`define XRS_A_CMD         4'h1
`define XRS_A_KV_SET      4'h2
`define XRS_A_CUR_SET     4'h3
`define XRS_A_FIL_SET     4'h4
`define XRS_A_KV_MS       4'h5
`define XRS_A_FIL_MS      4'h6
`define XRS_A_CUR_MS      4'h7
`define XRS_A_HOLD_MS     4'h8
`define XRS_A_ARC_LIM     4'h9
`define XRS_A_ARC_MS      4'ha
`define XRS_A_QU_MS       4'hb
`define XRS_A_STATUS      4'hc
// ==========================================================
// control bits and command bits
`define XRS_C_CTL_RAMP    0
`define XRS_C_SP_RAMP     1
`define XRS_C_DEF_REM     2
`define XRS_C_ARC_EN      3
`define XRS_C_NO_RERAMP   4
`define XRS_CTRL_RST      5'h08
`define XRS_K_REMOTE      0
`define XRS_K_LOCAL       1
`define XRS_K_HV_ON       2
`define XRS_K_HV_OFF      3
`define XRS_K_CLEAR       4
`define XRS_K_SAVE        5
// ==========================================================
// times in ms and arc counts: defaults, standard ramps and limits
`define XRS_STD_KV_MS     16'd5000
`define XRS_STD_FIL_MS    16'd2500
`define XRS_KV_MS_RST     16'd5000
`define XRS_KV_MS_MIN     16'd1000
`define XRS_KV_MS_MAX     16'd20000
`define XRS_FIL_MS_RST    16'd30000
`define XRS_FIL_MS_MIN    16'd500
`define XRS_FIL_MS_MAX    16'd30000
`define XRS_CUR_MS_RST    16'd5000
`define XRS_CUR_MS_MIN    16'd500
`define XRS_CUR_MS_MAX    16'd5000
`define XRS_HOLD_MS_RST   16'd30000
`define XRS_HOLD_MS_MIN   16'd1000
`define XRS_HOLD_MS_MAX   16'd30000
`define XRS_ARC_LIM_RST   16'd4
`define XRS_ARC_LIM_MIN   16'd2
`define XRS_ARC_LIM_MAX   16'd10
`define XRS_ARC_MS_RST    16'd10000
`define XRS_ARC_MS_MIN    16'd10000
`define XRS_ARC_MS_MAX    16'd20000
`define XRS_QU_MS_RST     16'd150
`define XRS_QU_MS_MIN     16'd50
`define XRS_QU_MS_MAX     16'd300
`endif

// file: rtl/xrs_ramp.v
`timescale 1ns/1ns
`include "xrs_regs.vh"
module xrs_ramp
#(
  parameter W = 12
)
(
  input  wire         sys_clk,
  input  wire         reset_n,
  input  wire [W-1:0] target,
  input  wire [31:0]  span,
  input  wire         slew,
  output reg  [W-1:0] value_r,
  output wire         done
);
  reg  [31:0] acc_r;
  wire [31:0] acc_sum;

  // full-scale code added every clock; one lsb per span overflow,
  // so a half-scale change takes half the span
  assign acc_sum = acc_r + {{(32-W){1'b0}}, `XRS_FS_CODE};
  assign done    = (value_r == target);

  // ==========================================================
  // slew engine
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      value_r <= {W{1'b0}};
      acc_r   <= 32'h0000_0000;
    end
    else if (!slew || done)
    begin
      value_r <= target;
      acc_r   <= 32'h0000_0000;
    end
    else if (acc_sum >= span)
    begin
      acc_r <= acc_sum - span;
      if (target > value_r)
        value_r <= value_r + {{(W-1){1'b0}}, 1'b1};
      else
        value_r <= value_r - {{(W-1){1'b0}}, 1'b1};
    end
    else
      acc_r <= acc_sum;
  end
endmodule // xrs_ramp

// file: rtl/xrs_arc_mem.v
`timescale 1ns/1ns
module xrs_arc_mem
#(
  parameter AW = 4,
  parameter DW = 32
)
(
  input  wire          sys_clk,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data_r
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // ==========================================================
  // timestamp store, registered read, no reset needed
  always @(posedge sys_clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data_r <= mem[rd_addr];
  end
endmodule // xrs_arc_mem

// file: test/xrs_seq_chk.sv
`timescale 1ns/1ns
// ==========================================================
// sequencer port checker
module xrs_seq_chk
#(
  parameter W = 12
)
(
  input wire         sys_clk,
  input wire         reset_n,
  input wire         enable_contact,
  input wire [3:0]   addr,
  input wire [15:0]  wr_data,
  input wire         wr_en,
  input wire [W-1:0] kv_prog,
  input wire         hv_on_r,
  input wire         ps_fault_r,
  input wire         arc_shutdown_r,
  input wire         nv_save_r
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // command decodes; a bit may act one or two edges on
  wire cmd = wr_en && addr == 4'h1;
  wire rem = cmd && wr_data[0];
  wire clr = cmd && wr_data[4];
  wire sv  = cmd && wr_data[5];
  hv_off_open_a: assert property (!enable_contact [*5] |-> !hv_on_r)
    else $error("hv on with contact open");
  hv_needs_contact_a: assert property (
    $rose(hv_on_r) |-> $past(enable_contact, 3))
    else $error("hv rose without contact");
  fault_hv_a: assert property (ps_fault_r |-> ##1 !hv_on_r)
    else $error("hv on during mode fault");
  shut_hv_a: assert property (arc_shutdown_r |-> ##1 !hv_on_r)
    else $error("hv on during arc shutdown");
  save_pulse_a: assert property (
    nv_save_r |-> ($past(sv) || $past(sv, 2)) ##1 !nv_save_r)
    else $error("bad save pulse");
  fault_clear_a: assert property (
    $fell(ps_fault_r) |-> $past(clr) || $past(clr, 2))
    else $error("fault dropped without clear");
  shut_clear_a: assert property (
    $fell(arc_shutdown_r) |-> $past(clr) || $past(clr, 2))
    else $error("arc shutdown dropped without clear");
  fault_cause_a: assert property (
    $rose(ps_fault_r) |-> $past(rem) || $past(rem, 2))
    else $error("fault without remote command");
  kv_zero_a: assert property (!hv_on_r [*3] |-> kv_prog == '0)
    else $error("kv program live while hv off");
endmodule // xrs_seq_chk

bind xrs_sequencer xrs_seq_chk #(.W(W)) u_chk (.sys_clk, .reset_n,
  .enable_contact, .addr, .wr_data, .wr_en, .kv_prog, .hv_on_r,
  .ps_fault_r, .arc_shutdown_r, .nv_save_r);

// file: test/xrs_field_model.sv
`timescale 1ns/1ns
// ==========================================================
// field side: dry contact and arc sensor
module xrs_field_model
(
  input  logic sys_clk,
  input  logic close_req,
  input  logic arc_req,
  output logic enable_contact = 1'b0,
  output logic arc_detect = 1'b0
);
  // no bounce modelled; levels follow one clock late
  always @(posedge sys_clk)
  begin
    enable_contact <= close_req;
    arc_detect     <= arc_req;
  end
endmodule // xrs_field_model

// file: test/xrs_sequencer_test.sv
`timescale 1ns/1ns
// ==========================================================
// sequencer bench; ms tick shrunk to 4 clocks to keep runs short
module xrs_sequencer_test;
  logic        sys_clk = 0;
  logic        reset_n = 0;
  logic        close_req = 0;
  logic        arc_req = 0;
  logic [4:0]  nv_ctrl = 5'h08;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wr_data = 16'h0000;
  logic        wr_en = 0;
  logic        rd_en = 0;
  wire  [15:0] rd_data_r;
  wire  [11:0] kv_prog, cur_prog, fil_prog;
  wire         enable_contact, arc_detect, hv_on_r, ps_fault_r;
  wire         arc_shutdown_r, remote_mode_r, nv_save_r;
  int          fail_count = 0;
  int          checked = 0;
  int          n;
  logic [15:0] dflt [7] = '{16'h1388, 16'h7530, 16'h1388, 16'h7530,
                            16'h0004, 16'h2710, 16'h0096};
  always #25 sys_clk = ~sys_clk;
  xrs_sequencer #(.MS_CYCLES(4)) u_xrs_sequencer (.sys_clk, .reset_n,
    .enable_contact, .arc_detect, .nv_ctrl, .addr, .wr_data, .wr_en,
    .rd_en, .rd_data_r, .kv_prog, .cur_prog, .fil_prog, .hv_on_r,
    .ps_fault_r, .arc_shutdown_r, .remote_mode_r, .nv_save_r);
  xrs_field_model u_xrs_field_model (.sys_clk, .close_req, .arc_req,
    .enable_contact, .arc_detect);
  // compare helpers
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task ok(input logic c);
    chk({15'h0000, c}, 16'h0001);
  endtask
  // register bus cycles
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1;
    @(posedge sys_clk);
    wr_en <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1;
    @(posedge sys_clk);
    rd_en <= 0;
    @(negedge sys_clk);
    chk(rd_data_r, e);
  endtask
  // wait for a program to reach a level, cycles left in n
  task wsig(input bit c, input logic [11:0] t, input int lim);
    n = 0;
    while ((c ? cur_prog : kv_prog) !== t && n < lim)
    begin
      @(negedge sys_clk);
      n++;
    end
    ok(n < lim);
  endtask
  task contact(input logic v);
    @(posedge sys_clk);
    close_req <= v;
  endtask
  task arc;
    @(posedge sys_clk);
    arc_req <= 1;
    repeat (3) @(posedge sys_clk);
    arc_req <= 0;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: the tests need about 50k clocks
  initial
  begin
    #(100000 * 50);
    fail_count++;
    give_verdict;
  end
  // test sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 7; i++)
      rd(4'(5 + i), dflt[i]);
    rd(4'h0, 16'h0808);
    rd(4'hd, 16'h0000);
    chk(remote_mode_r, 0);
    wr(4'h9, 16'h0001);
    rd(4'h9, 16'h0002);
    wr(4'h9, 16'h000b);
    rd(4'h9, 16'h000a);
    wr(4'ha, 16'h0fa0);
    rd(4'ha, 16'h2710);
    wr(4'hb, 16'h0190);
    rd(4'hb, 16'h012c);
    $display("registers done");
    wr(4'h2, 16'h0fff);
    wr(4'h3, 16'h0800);
    wr(4'h4, 16'h0fff);
    contact(1);
    wsig(0, 12'h4cc, 30000);
    chk(fil_prog, 0);
    wsig(0, 12'hfff, 30000);
    ok(n > 13800 && n < 14200);
    repeat (10) @(negedge sys_clk);
    chk(fil_prog, 12'hfff);
    chk(cur_prog, 12'h800);
    contact(0);
    repeat (8) @(negedge sys_clk);
    chk(hv_on_r, 0);
    $display("standard ramp done");
    wr(4'h5, 16'h07d0);
    wr(4'h6, 16'h01f4);
    wr(4'h7, 16'h07d0);
    wr(4'h8, 16'h03e8);
    wr(4'h0, 16'h0009);
    wr(4'h1, 16'h0020);
    rd(4'h0, 16'h0909);
    contact(1);
    wsig(0, 12'hfff, 9000);
    ok(n > 7900 && n < 8100);
    repeat (20) @(negedge sys_clk);
    chk(cur_prog, 12'h066);
    repeat (1000) @(negedge sys_clk);
    chk(cur_prog, 12'h066);
    ok(fil_prog > 0 && fil_prog < 12'hfff);
    wsig(1, 12'h800, 9000);
    ok(n > 6600 && n < 7000);
    $display("controlled ramp done");
    wr(4'h0, 16'h000b);
    wr(4'h1, 16'h0020);
    wr(4'h2, 16'h0800);
    wsig(0, 12'h800, 6000);
    ok(n > 3900 && n < 4100);
    wr(4'h3, 16'h0fff);
    wsig(1, 12'hfff, 6000);
    ok(n > 3900 && n < 4100);
    $display("set-point ramp done");
    arc;
    repeat (8) @(negedge sys_clk);
    chk(hv_on_r, 0);
    repeat (1150) @(negedge sys_clk);
    chk(hv_on_r, 0);
    wsig(0, 12'h800, 8000);
    ok(n > 1500);
    chk(hv_on_r, 1);
    wr(4'h9, 16'h0002);
    arc;
    repeat (10) @(negedge sys_clk);
    chk(arc_shutdown_r, 1);
    wr(4'h1, 16'h0010);
    repeat (2) @(negedge sys_clk);
    chk(arc_shutdown_r, 0);
    $display("arc handling done");
    wr(4'h1, 16'h0001);
    repeat (4) @(negedge sys_clk);
    chk(ps_fault_r, 1);
    chk(hv_on_r, 0);
    wr(4'h1, 16'h0010);
    repeat (2) @(negedge sys_clk);
    chk(ps_fault_r, 0);
    contact(0);
    repeat (4) @(posedge sys_clk);
    wr(4'h1, 16'h0004);
    repeat (10) @(negedge sys_clk);
    chk(hv_on_r, 0);
    contact(1);
    repeat (8) @(negedge sys_clk);
    chk(hv_on_r, 0);
    wr(4'h1, 16'h0004);
    repeat (10) @(negedge sys_clk);
    chk(hv_on_r, 1);
    $display("mode handling done");
    @(posedge sys_clk);
    reset_n <= 0;
    nv_ctrl <= 5'h0c;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1;
    repeat (8) @(negedge sys_clk);
    chk(remote_mode_r, 1);
    chk(hv_on_r, 0);
    $display("power-up mode done");
    give_verdict;
  end
endmodule // xrs_sequencer_test
